// ==== rtl/osrc_consts.svh ====
`ifndef OSRC_CONSTS_SVH
`define OSRC_CONSTS_SVH

// register offsets (12-bit register address space)
`define OSRC_A_SPCFG 12'h000
`define OSRC_A_DRV0 12'h0f0
`define OSRC_A_DRVN 12'h0fb
`define OSRC_A_DIV0 12'h190
`define OSRC_A_PH0 12'h191
`define OSRC_A_DSYNC 12'h230
`define OSRC_A_XFER 12'h232
// channel registers repeat every three addresses
`define OSRC_CH_STRIDE 12'h003

// serial port config fields
`define OSRC_SR_HI 5
`define OSRC_SR_LO 2
// distribution sync control fields
`define OSRC_DS_SOFT 0
`define OSRC_DS_PD 1
// register transfer control field
`define OSRC_XF_UPD 0
// output driver control fields
`define OSRC_DRV_PD 0
`define OSRC_DRV_INV 1
`define OSRC_DRV_INVB 2
`define OSRC_DRV_SE 3
`define OSRC_DRV_EN_A 5
`define OSRC_DRV_EN_B 6
// phase register fields
`define OSRC_PH_IGN 5
`define OSRC_PH_SH 4

// on-chip default values
`define OSRC_SPCFG_RST 8'h00
`define OSRC_DRV_RST 8'h00
`define OSRC_DIV_RST 8'h00
`define OSRC_PH_RST 8'h00
`define OSRC_DSYNC_RST 8'h00

// timing, clock is the channel divider input at 20 MHz
`define OSRC_CLK_KHZ 20000
`define OSRC_CLK_PERIOD_NS 50
`define OSRC_SYNC_PIPE_CYC 4'hc
`define OSRC_POR_WAIT_MS 70
`define OSRC_NVM_WAIT_MS 20
`define OSRC_HW_WAIT_NS 2000
`define OSRC_POR_WAIT_CYC (`OSRC_POR_WAIT_MS * `OSRC_CLK_KHZ)
`define OSRC_NVM_WAIT_CYC (`OSRC_NVM_WAIT_MS * `OSRC_CLK_KHZ)
`define OSRC_HW_WAIT_CYC (`OSRC_HW_WAIT_NS / `OSRC_CLK_PERIOD_NS)

`endif

// ==== rtl/osrc_pkg.sv ====
package osrc_pkg;
  // one register byte
  typedef logic [7:0] osrc_byte_t;
  // restore sequencer: idle, pin reset, soft reset, settle wait
  typedef enum logic [1:0] {
    RS_IDLE,
    RS_HARD,
    RS_SOFT,
    RS_WAIT
  } osrc_rst_state_t;
endpackage

// ==== rtl/osrc_sync2.sv ====
// two-stage synchroniser for the three active-low request pins
module osrc_sync2 (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [2:0] async_i,
  output logic [2:0] sync_o
);
  // first stage, read only by the second stage
  logic [2:0] meta;

  // idle level of an active-low pin is high
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta <= 3'h7;
      sync_o <= 3'h7;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// ==== rtl/osrc_top.sv ====
// Notes on behaviour
// - align pin low then high performs sync
// - soft sync, reset mirror, distribution pd sync
// - soft sync bits apply on update-all write
// - calibration in progress holds sync
// - reset or sleep pin pulse also syncs
// - outputs start 16-17 cycles after release
// - release resolved with one cycle uncertainty
// - included channels hold static preset level
// - new phase applies only after a sync
// - excluded channels keep toggling through sync
// - channel sync state drives all three drivers
// - per-output polarity and power-down
// - single-ended mode auto-enables both outputs
// - disabled single-ended driver is tristated
// - power-on restores by boot pin, then syncs
// - reset pin restores, syncs, waits 2us/20ms
// - both soft reset bits reset the chip
// - soft reset keeps config register except bits
// - outputs static during internal soft reset
// - soft bits clear after one more serial clock
// - delay phi, or phi-16+M+1 above fifteen
`include "osrc_consts.svh"
module osrc_top
  import osrc_pkg::*;
#(
  parameter int unsigned POR_WAIT_CYC = `OSRC_POR_WAIT_CYC,
  parameter int unsigned NVM_WAIT_CYC = `OSRC_NVM_WAIT_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic align_req_n_i,
  input wire logic reset_req_n_i,
  input wire logic sleep_request_n_i,
  input wire logic boot_src_i,
  input wire logic cal_busy_i,
  input wire logic sclk_tick_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic [11:0] drv_o,
  output logic [11:0] drv_oe_o,
  output logic [11:0] cmos_a_o,
  output logic [11:0] cmos_a_oe_o,
  output logic [11:0] cmos_b_o,
  output logic [11:0] cmos_b_oe_o,
  output logic sync_busy_o,
  output logic restore_busy_o,
  output logic restore_nvm_o
);
  // synchronised pins: bit0 align, bit1 reset, bit2 sleep
  logic [2:0] pins_s;
  logic align_n_s;
  logic reset_n_s;
  logic sleep_n_s;
  // register file
  osrc_byte_t spcfg;
  osrc_byte_t drv [12];
  osrc_byte_t div_cfg [4];
  osrc_byte_t ph_cfg [4];
  osrc_byte_t dsync_buf;
  osrc_byte_t dsync;
  osrc_byte_t rd_val;
  // restore sequencer
  osrc_rst_state_t rst_state;
  logic [20:0] rcnt;
  logic boot_lat;
  logic restore_now;
  logic soft_busy;
  logic sr_active;
  // sync sequencing
  logic hold_src;
  logic [3:0] pipe_cnt;
  logic sync_busy;
  logic [3:0] hold_ch;
  logic awake;
  // channel divider state
  logic [3:0] ch_lvl;
  logic [3:0] ch_run;
  logic [3:0] ch_cnt [4];
  logic [5:0] ch_dly [4];
  // assertion helper: cycles since last hold request
  logic [4:0] rel_age;

  osrc_sync2 u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i({sleep_request_n_i, reset_req_n_i, align_req_n_i}),
    .sync_o(pins_s)
  );
  assign align_n_s = pins_s[0];
  assign reset_n_s = pins_s[1];
  assign sleep_n_s = pins_s[2];

  // both soft reset bits request chip reset
  assign sr_active = spcfg[`OSRC_SR_HI] & spcfg[`OSRC_SR_LO];
  // driver, channel and sync registers fall back to defaults while a reset is applied
  assign restore_now = (rst_state == RS_HARD) | (rst_state == RS_SOFT);
  assign soft_busy = (rst_state == RS_SOFT);
  // outputs stay off while asleep or distribution is powered down
  assign awake = sleep_n_s & ~dsync[`OSRC_DS_PD];

  // restore sequencer and settle counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rst_state <= RS_WAIT;
      rcnt <= 21'(POR_WAIT_CYC);
    end else begin
      case (rst_state)
        RS_IDLE: begin
          if (!reset_n_s) begin
            rst_state <= RS_HARD;
          end else if (sr_active) begin
            rst_state <= RS_SOFT;
          end
        end
        RS_HARD: begin
          // settle time depends on restore source
          if (reset_n_s) begin
            rst_state <= RS_WAIT;
            rcnt <= boot_src_i ? 21'(NVM_WAIT_CYC)
                               : 21'(`OSRC_HW_WAIT_CYC);
          end
        end
        RS_SOFT: begin
          // held here until the bits self-clear
          if (!reset_n_s) begin
            rst_state <= RS_HARD;
          end else if (!sr_active) begin
            rst_state <= RS_WAIT;
            rcnt <= boot_src_i ? 21'(NVM_WAIT_CYC)
                               : 21'(`OSRC_HW_WAIT_CYC);
          end
        end
        RS_WAIT: begin
          if (!reset_n_s) begin
            rst_state <= RS_HARD;
          end else if (rcnt == 21'h0) begin
            rst_state <= RS_IDLE;
          end else begin
            rcnt <= rcnt - 21'h1;
          end
        end
        default: begin
          rst_state <= RS_IDLE;
        end
      endcase
    end
  end

  // restore source seen at the last reset, for status only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      boot_lat <= boot_src_i;
    end else if (restore_now) begin
      boot_lat <= boot_src_i;
    end
  end

  // serial port config, survives soft reset apart from its two bits
  always_ff @(posedge clk_i) begin
    if (srst_i || rst_state == RS_HARD) begin
      spcfg <= `OSRC_SPCFG_RST;
    end else if (reg_we_i && reg_addr_i == `OSRC_A_SPCFG) begin
      // a fresh write wins over the self-clear
      spcfg <= reg_wdata_i;
    end else if (soft_busy && sclk_tick_i) begin
      // only the soft reset bits clear
      spcfg[`OSRC_SR_HI] <= 1'b0;
      spcfg[`OSRC_SR_LO] <= 1'b0;
    end
  end

  // output driver control registers
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 12; i++) begin
      if (srst_i || restore_now) begin
        drv[i] <= `OSRC_DRV_RST;
      end else if (reg_we_i &&
                   reg_addr_i == `OSRC_A_DRV0 + 12'(i)) begin
        drv[i] <= reg_wdata_i;
        // entering single-ended turns on A and B
        if (reg_wdata_i[`OSRC_DRV_SE] && !drv[i][`OSRC_DRV_SE]) begin
          drv[i][`OSRC_DRV_EN_A] <= 1'b1;
          drv[i][`OSRC_DRV_EN_B] <= 1'b1;
        end
      end
    end
  end

  // channel divide and phase registers
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 4; c++) begin
      if (srst_i || restore_now) begin
        div_cfg[c] <= `OSRC_DIV_RST;
        ph_cfg[c] <= `OSRC_PH_RST;
      end else if (reg_we_i) begin
        if (reg_addr_i == `OSRC_A_DIV0 + 12'(c) * `OSRC_CH_STRIDE) begin
          div_cfg[c] <= reg_wdata_i;
        end else if (reg_addr_i ==
                     `OSRC_A_PH0 + 12'(c) * `OSRC_CH_STRIDE) begin
          ph_cfg[c] <= reg_wdata_i;
        end
      end
    end
  end

  // distribution sync control: buffered, applied on transfer
  always_ff @(posedge clk_i) begin
    if (srst_i || restore_now) begin
      dsync_buf <= `OSRC_DSYNC_RST;
      dsync <= `OSRC_DSYNC_RST;
    end else begin
      if (reg_we_i && reg_addr_i == `OSRC_A_DSYNC) begin
        dsync_buf <= reg_wdata_i;
      end
      // both set and clear need the update write
      if (reg_we_i && reg_addr_i == `OSRC_A_XFER &&
          reg_wdata_i[`OSRC_XF_UPD]) begin
        dsync <= dsync_buf;
      end
    end
  end

  // read decode; unknown and write-only addresses read zero
  always_comb begin
    rd_val = 8'h00;
    if (reg_addr_i == `OSRC_A_SPCFG) begin
      rd_val = spcfg;
    end else if (reg_addr_i == `OSRC_A_DSYNC) begin
      rd_val = dsync_buf;
    end else begin
      for (int i = 0; i < 12; i++) begin
        if (reg_addr_i == `OSRC_A_DRV0 + 12'(i)) begin
          rd_val = drv[i];
        end
      end
      for (int c = 0; c < 4; c++) begin
        if (reg_addr_i == `OSRC_A_DIV0 + 12'(c) * `OSRC_CH_STRIDE) begin
          rd_val = div_cfg[c];
        end else if (reg_addr_i ==
                     `OSRC_A_PH0 + 12'(c) * `OSRC_CH_STRIDE) begin
          rd_val = ph_cfg[c];
        end
      end
    end
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      reg_rdata_o <= rd_val;
    end
  end

  // reset and sleep pins also hold the sync
  assign hold_src = ~align_n_s | dsync[`OSRC_DS_SOFT] |
                    dsync[`OSRC_DS_PD] | spcfg[`OSRC_SR_HI] |
                    cal_busy_i | ~sleep_n_s | (rst_state != RS_IDLE);

  // fixed pipeline after release; the pin synchroniser
  always_ff @(posedge clk_i) begin
    if (srst_i || hold_src) begin
      pipe_cnt <= `OSRC_SYNC_PIPE_CYC;
    end else if (pipe_cnt != 4'h0) begin
      pipe_cnt <= pipe_cnt - 4'h1;
    end
  end
  assign sync_busy = hold_src | (pipe_cnt != 4'h0);

  // channel dividers, one per output triplet
  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic [5:0] dly_new;
    assign dly_new = ph_cfg[c][`OSRC_PH_SH] ?
                     ({2'b00, ph_cfg[c][3:0]} +
                      {2'b00, div_cfg[c][7:4]} + 6'h01) :
                     {2'b00, ph_cfg[c][3:0]};
    // every channel static in soft reset
    assign hold_ch[c] = (sync_busy & ~ph_cfg[c][`OSRC_PH_IGN]) |
                        soft_busy;

    // high phase is N+1 cycles, low phase M+1 cycles
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        ch_lvl[c] <= 1'b0;
        ch_run[c] <= 1'b0;
        ch_cnt[c] <= 4'h0;
        ch_dly[c] <= 6'h00;
      end else if (hold_ch[c]) begin
        // static level from the initial-level bit
        // delay is captured only while held
        ch_lvl[c] <= ph_cfg[c][`OSRC_PH_SH];
        ch_run[c] <= 1'b0;
        ch_cnt[c] <= 4'h0;
        ch_dly[c] <= dly_new;
      end else if (!ch_run[c]) begin
        // phase delay before the first rising edge
        if (ch_dly[c] == 6'h00) begin
          ch_run[c] <= 1'b1;
          ch_lvl[c] <= 1'b1;
          ch_cnt[c] <= div_cfg[c][3:0];
        end else begin
          ch_dly[c] <= ch_dly[c] - 6'h01;
        end
      end else if (ch_cnt[c] == 4'h0) begin
        ch_lvl[c] <= ~ch_lvl[c];
        ch_cnt[c] <= ch_lvl[c] ? div_cfg[c][7:4] : div_cfg[c][3:0];
      end else begin
        ch_cnt[c] <= ch_cnt[c] - 4'h1;
      end
    end
  end

  // output drivers; diff pair off when it is single-ended
  for (genvar j = 0; j < 12; j++) begin : g_drv
    localparam int CH = j / 3;
    // three drivers share one channel level
    // a disabled single-ended output is tristated
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        drv_o[j] <= 1'b0;
        drv_oe_o[j] <= 1'b0;
        cmos_a_o[j] <= 1'b0;
        cmos_a_oe_o[j] <= 1'b0;
        cmos_b_o[j] <= 1'b0;
        cmos_b_oe_o[j] <= 1'b0;
      end else begin
        drv_o[j] <= ch_lvl[CH] ^ drv[j][`OSRC_DRV_INV];
        drv_oe_o[j] <= awake & ~drv[j][`OSRC_DRV_PD] &
                       ~drv[j][`OSRC_DRV_SE];
        cmos_a_o[j] <= ch_lvl[CH] ^ drv[j][`OSRC_DRV_INV];
        cmos_a_oe_o[j] <= awake & drv[j][`OSRC_DRV_SE] &
                          drv[j][`OSRC_DRV_EN_A];
        cmos_b_o[j] <= ch_lvl[CH] ^ drv[j][`OSRC_DRV_INVB];
        cmos_b_oe_o[j] <= awake & drv[j][`OSRC_DRV_SE] &
                          drv[j][`OSRC_DRV_EN_B];
      end
    end
  end

  // status outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync_busy_o <= 1'b1;
      restore_busy_o <= 1'b1;
      restore_nvm_o <= 1'b0;
    end else begin
      sync_busy_o <= sync_busy;
      restore_busy_o <= (rst_state != RS_IDLE);
      restore_nvm_o <= (rst_state != RS_IDLE) & boot_lat;
    end
  end

  // helper: saturating age of the current release
  always_ff @(posedge clk_i) begin
    if (srst_i || hold_src) begin
      rel_age <= 5'h00;
    end else if (rel_age != 5'h1f) begin
      rel_age <= rel_age + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_pin_hold: assert property (
    !align_n_s |-> sync_busy ##1 sync_busy)
    else $error("align pin low did not hold sync");
  a_update_gate: assert property (
    $changed(dsync) && !$past(restore_now) |->
      $past(reg_we_i && reg_addr_i == `OSRC_A_XFER))
    else $error("soft sync changed without update write");
  a_cal_hold: assert property (
    cal_busy_i |-> sync_busy)
    else $error("calibration did not hold sync");
  a_pipe_busy: assert property (
    !hold_src && rel_age < 5'h0c |-> sync_busy)
    else $error("sync released before pipeline end");
  a_pipe_end: assert property (
    rel_age == 5'h0c && !hold_src |-> !sync_busy)
    else $error("sync not released at pipeline end");
  a_static_lvl: assert property (
    hold_ch[0] ##1 hold_ch[0] |-> ch_lvl[0] == $past(ph_cfg[0][4]))
    else $error("held channel not at preset level");
  a_excl_runs: assert property (
    ch_run[0] && ph_cfg[0][5] && !soft_busy && sync_busy |=> ch_run[0])
    else $error("excluded channel stopped during sync");
  a_auto_enable: assert property (
    reg_we_i && reg_addr_i == `OSRC_A_DRV0 + 12'h001 && reg_wdata_i[3] &&
      !drv[1][3] && !restore_now |=> drv[1][6:5] == 2'b11)
    else $error("single-ended mode did not enable A and B");
  a_tristate: assert property (
    !drv[1][5] |=> !cmos_a_oe_o[1])
    else $error("disabled single-ended output driven");
  a_soft_static: assert property (
    soft_busy |-> hold_ch == 4'hf)
    else $error("channel toggling during soft reset");
  a_soft_clear: assert property (
    soft_busy && sclk_tick_i && !reg_we_i |=> !sr_active ##1 !soft_busy)
    else $error("soft reset bits did not self-clear");

  c_pin_sync: cover property (!align_n_s ##1 align_n_s);
  c_soft_reset: cover property (soft_busy ##1 !soft_busy);
  c_phase_run: cover property ($rose(ch_run[0]) && ph_cfg[0][4]);
endmodule

// ==== tb/osrc_host.sv ====
// host controller: drives the request pins and the register port
module osrc_host (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic align_req_n_o,
  output logic reset_req_n_o,
  output logic sleep_request_n_o,
  output logic sclk_tick_o,
  output logic reg_we_o,
  output logic reg_re_o,
  output logic [11:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels at time zero, pins released high
  initial begin
    {align_req_n_o, reset_req_n_o, sleep_request_n_o} = 3'b111;
    sclk_tick_o = 1'b0;
    reg_we_o = 1'b0;
    reg_re_o = 1'b0;
    reg_addr_o = 12'h000;
    reg_wdata_o = 8'h00;
  end

  // pins move at falling edge, held until next call
  task automatic set_pins(input logic [2:0] v);
    @(negedge clk_i);
    {align_req_n_o, reset_req_n_o, sleep_request_n_o} = v;
  endtask

  // one write, strobe held across exactly one taking edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_we_o = 1'b1;
    @(negedge clk_i);
    reg_we_o = 1'b0;
    // idle data inverted so a stale byte is never mistaken
    reg_wdata_o = ~d;
  endtask

  // read; data taken one and a half cycles after the taking edge
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_re_o = 1'b1;
    @(negedge clk_i);
    reg_re_o = 1'b0;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask

  // update-all write commits buffered sync bits
  task automatic upd();
    wr(12'h232, 8'h01);
  endtask

  // extra serial clock so self-clearing bits finish
  task automatic tick();
    @(negedge clk_i);
    sclk_tick_o = 1'b1;
    @(negedge clk_i);
    sclk_tick_o = 1'b0;
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the sync and reset control block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic srst_i;
  logic boot_src_i;
  logic cal_busy_i;
  logic align_n, reset_n, sleep_n, tick, we, re;
  logic [11:0] addr;
  logic [7:0] wdata, rdata_o;
  logic [11:0] drv_o, drv_oe_o, ca_o, ca_oe_o, cb_o, cb_oe_o;
  logic sync_busy_o, restore_busy_o, restore_nvm_o;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] seed;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  // short settle counts keep the run brief
  osrc_top #(.POR_WAIT_CYC(20), .NVM_WAIT_CYC(10)) u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .align_req_n_i(align_n),
    .reset_req_n_i(reset_n), .sleep_request_n_i(sleep_n),
    .boot_src_i(boot_src_i), .cal_busy_i(cal_busy_i),
    .sclk_tick_i(tick), .reg_we_i(we), .reg_re_i(re),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata_o),
    .drv_o(drv_o), .drv_oe_o(drv_oe_o), .cmos_a_o(ca_o),
    .cmos_a_oe_o(ca_oe_o), .cmos_b_o(cb_o), .cmos_b_oe_o(cb_oe_o),
    .sync_busy_o(sync_busy_o), .restore_busy_o(restore_busy_o),
    .restore_nvm_o(restore_nvm_o));

  osrc_host u_host (
    .clk_i(clk_i), .reg_rdata_i(rdata_o), .align_req_n_o(align_n),
    .reset_req_n_o(reset_n), .sleep_request_n_o(sleep_n),
    .sclk_tick_o(tick), .reg_we_o(we), .reg_re_o(re),
    .reg_addr_o(addr), .reg_wdata_o(wdata));

  // xorshift step for repeatable stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // verdict and end of run, the only exit
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // single comparison point, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // read a register and compare
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask

  // bounded wait for sync (sel=1) or restore (sel=0) to go idle
  task automatic wait_low(input bit sel, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk_i);
      if ((sel ? sync_busy_o : restore_busy_o) === 1'b0) return;
    end
    n_errors++;
    $display("Error at %0t: seen %h expected %h", $time, 1'b1, 1'b0);
    conclude();
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // main sequence
  initial begin
    int idx, k, tog;
    logic [11:0] a, v;
    logic [7:0] d;
    logic prev;
    srst_i = 1'b1;
    boot_src_i = 1'b0;
    cal_busy_i = 1'b0;
    seed = 32'hdfd6;
    wait_n(4);
    srst_i = 1'b0;
    chk(restore_busy_o, 1'b1);
    chk(restore_nvm_o, 1'b0);
    wait_low(0, 200);
    wait_low(1, 100);
    // defaults, write-only transfer byte, unmapped place
    rchk(12'h0f0, 8'h00);
    rchk(12'h230, 8'h00);
    rchk(12'h232, 8'h00);
    rchk(12'h400, 8'h00);
    // random driver settings, single-ended mode kept off
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      idx = int'(seed[7:0]) % 12;
      a = 12'h0f0 + 12'(idx);
      d = seed[15:8] & 8'h67;
      // random side inputs, none of them reach the enables
      boot_src_i = seed[16];
      cal_busy_i = seed[17];
      u_host.set_pins({seed[18], 2'b11});
      u_host.wr(a, d);
      rchk(a, d);
      chk(drv_oe_o[idx], !d[0]);
    end
    boot_src_i = 1'b0;
    cal_busy_i = 1'b0;
    u_host.set_pins(3'b111);
    for (int i = 0; i < 12; i++) u_host.wr(12'h0f0 + 12'(i), 8'h00);
    wait_low(1, 40);
    // soft sync bit and distribution power-down, both via update
    for (int b = 0; b < 2; b++) begin
      u_host.wr(12'h230, 8'h01 << b);
      wait_n(4);
      chk(sync_busy_o, 1'b0);
      u_host.upd();
      wait_n(3);
      chk(sync_busy_o, 1'b1);
      u_host.wr(12'h230, 8'h00);
      wait_n(4);
      chk(sync_busy_o, 1'b1);
      u_host.upd();
      wait_low(1, 40);
    end
    // mirrored soft reset bit alone
    u_host.wr(12'h000, 8'h20);
    wait_n(3);
    chk(sync_busy_o, 1'b1);
    u_host.wr(12'h000, 8'h00);
    wait_low(1, 40);
    // calibration holds a sync
    cal_busy_i = 1'b1;
    wait_n(4);
    chk(sync_busy_o, 1'b1);
    cal_busy_i = 1'b0;
    wait_low(1, 40);
    // ch0 excluded, ch2 starts high, drv4 inverted, drv5 down
    u_host.wr(12'h191, 8'h20);
    u_host.wr(12'h197, 8'h10);
    u_host.wr(12'h0f4, 8'h02);
    u_host.wr(12'h0f5, 8'h01);
    u_host.set_pins(3'b011);
    wait_n(3);
    chk(sync_busy_o, 1'b1);
    tog = 0;
    prev = drv_o[0];
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      if (drv_o[0] !== prev) tog++;
      prev = drv_o[0];
      chk({drv_o[11:6], drv_o[4:3]}, 8'h1e);
    end
    chk(tog != 0, 1'b1);
    chk(drv_o[2:0] === {3{drv_o[0]}}, 1'b1);
    chk(drv_oe_o[5:3], 3'b011);
    u_host.set_pins(3'b111);
    k = 0;
    while (drv_o[3] !== 1'b1 && k < 40) begin
      @(negedge clk_i);
      k++;
    end
    chk(k >= 15 && k <= 17, 1'b1);
    // single-ended: both on, then B alone
    u_host.wr(12'h0f1, 8'h08);
    wait_n(2);
    chk({ca_oe_o[1], cb_oe_o[1]}, 2'b11);
    u_host.wr(12'h0f1, 8'h4c);
    wait_n(2);
    chk({ca_oe_o[1], cb_oe_o[1]}, 2'b01);
    chk(cb_o[1], !ca_o[1]);
    // sleep pin: everything released, sync held
    u_host.set_pins(3'b110);
    wait_n(4);
    chk(drv_oe_o | ca_oe_o | cb_oe_o, 12'h000);
    chk(sync_busy_o, 1'b1);
    u_host.set_pins(3'b111);
    wait_low(1, 40);
    // soft reset from defaults, extra bits of 0x000 kept
    u_host.wr(12'h0f0, 8'h02);
    u_host.wr(12'h000, 8'ha5);
    // four cycles for the held levels to reach their defaults
    wait_n(4);
    chk(restore_busy_o, 1'b1);
    v = drv_o;
    wait_n(5);
    chk(drv_o, v);
    chk(restore_busy_o, 1'b1);
    u_host.tick();
    chk(restore_nvm_o, 1'b0);
    wait_low(0, 200);
    rchk(12'h000, 8'h81);
    rchk(12'h0f0, 8'h00);
    wait_low(1, 100);
    // pin reset with nonvolatile source
    boot_src_i = 1'b1;
    u_host.set_pins(3'b101);
    // source is latched one cycle after the restore starts
    wait_n(5);
    chk(restore_nvm_o, 1'b1);
    u_host.set_pins(3'b111);
    wait_low(0, 100);
    rchk(12'h000, 8'h00);
    rchk(12'h0f1, 8'h00);
    wait_low(1, 100);
    conclude();
  end
endmodule
